// ===== gtm_pkg.sv
// package of register offsets, field positions and constants for the 16-bit timer
package gtm_pkg;

  // ==========================================================
  // register offsets (word addresses on the plain register port)
  localparam logic [3:0] OFS_COUNT   = 4'h0;
  localparam logic [3:0] OFS_PERIOD  = 4'h1;
  localparam logic [3:0] OFS_CONTROL = 4'h2;
  localparam logic [3:0] OFS_STATUS  = 4'h3;
  localparam logic [3:0] OFS_ENABLE  = 4'h4;
  localparam logic [3:0] OFS_CLEAR   = 4'h5;

  // ==========================================================
  // control register field positions
  localparam int BIT_TIMER_ON     = 15;
  localparam int BIT_STOP_IDLE    = 13;
  localparam int BIT_GATE_ACC     = 6;
  localparam int BIT_PRESCALE_HI  = 5;
  localparam int BIT_PRESCALE_LO  = 4;
  localparam int BIT_EXT_SYNC     = 2;
  localparam int BIT_CLOCK_SOURCE = 1;

  // ==========================================================
  // status / enable bit positions
  localparam int EVT_MATCH = 0;
  localparam int EVT_GATE  = 1;
  localparam int EVT_NUM   = 2;

  // ==========================================================
  // values after reset and the mask of implemented control bits
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  localparam logic [15:0] RST_PERIOD  = 16'hffff;
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] CONTROL_MASK = 16'ha076;

  // ==========================================================
  // prescale select encodings and terminal counts
  localparam logic [1:0] PS_DIV1   = 2'h0;
  localparam logic [1:0] PS_DIV8   = 2'h1;
  localparam logic [1:0] PS_DIV64  = 2'h2;
  localparam logic [1:0] PS_DIV256 = 2'h3;
  localparam logic [7:0] PS_TOP1   = 8'h00;
  localparam logic [7:0] PS_TOP8   = 8'h07;
  localparam logic [7:0] PS_TOP64  = 8'h3f;
  localparam logic [7:0] PS_TOP256 = 8'hff;

  // ==========================================================
  // timing: one instruction cycle per clk_in cycle (100 ns at 10 MHz)
  localparam int CLK_PERIOD_NS = 100;
  localparam int TCY_NS        = 100;
  localparam int TCY_CYCLES    = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== gtm_sync.sv
// two flip-flop synchroniser for a single level from outside the clock domain
`timescale 1ns/1ps
module gtm_sync
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // level in and out
  input  wire logic async_in,
  output logic      sync_out
);
  import gtm_pkg::*;

  logic stage1;

  // ==========================================================
  // first stage read only by the second
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ===== gtm_prescaler.sv
// prescaler dividing count pulses by 1, 8, 64 or 256
`timescale 1ns/1ps
module gtm_prescaler
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // control
  input  wire logic       clear_in,
  input  wire logic [1:0] select_in,
  input  wire logic       tick_in,
  // divided tick
  output logic            tick_out
);
  import gtm_pkg::*;

  logic [7:0] count;
  logic [7:0] top;

  // ==========================================================
  // terminal count per select encoding
  function automatic logic [7:0] top_of(input logic [1:0] sel);
    case (sel)
      PS_DIV1:   top_of = PS_TOP1;
      PS_DIV8:   top_of = PS_TOP8;
      PS_DIV64:  top_of = PS_TOP64;
      default:   top_of = PS_TOP256;
    endcase
  endfunction

  assign top = top_of(select_in);
  assign tick_out = tick_in && (count >= top);

  // ==========================================================
  // divider counter, cleared by request; only moves on an input tick
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      count <= 8'h00;
    else if (clear_in)
      count <= 8'h00;
    else if (tick_in)
    begin
      if (count >= top)
        count <= 8'h00;
      else
        count <= count + 8'h01;
    end
  end
endmodule

// ===== gtm_timer.sv
// 16-bit general timer/counter with prescaler, gate and interrupt logic
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module gtm_timer
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic [15:0]      reg_rdata_out,
  // cpu power state
  input  wire logic        cpu_idle_in,
  input  wire logic        cpu_sleep_in,
  // external clock / gate pin
  input  wire logic        external_clock_gate_pin_in,
  // interrupt
  output logic             irq_out
);
  import gtm_pkg::*;

  // ==========================================================
  // register state
  logic [15:0]        count_register;
  logic [15:0]        period_register;
  logic [15:0]        control_register;
  logic [EVT_NUM-1:0] status;
  logic [EVT_NUM-1:0] match_interrupt_enable;

  // ==========================================================
  // control fields
  logic       timer_on_bit;
  logic       stop_in_idle_bit;
  logic       gate_accumulate_enable;
  logic [1:0] prescale_select;
  logic       external_sync_select;
  logic       clock_source_select;

  assign timer_on_bit           = control_register[BIT_TIMER_ON];
  assign stop_in_idle_bit       = control_register[BIT_STOP_IDLE];
  assign gate_accumulate_enable = control_register[BIT_GATE_ACC];
  assign prescale_select        = control_register[BIT_PRESCALE_HI:BIT_PRESCALE_LO];
  assign external_sync_select   = control_register[BIT_EXT_SYNC];
  assign clock_source_select    = control_register[BIT_CLOCK_SOURCE];

  // ==========================================================
  // register access decode
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic write_count;
  logic write_period;
  logic write_control;
  logic write_enable;
  logic write_clear;

  assign write_count   = reg_write_in && hit(reg_addr_in, OFS_COUNT);
  assign write_period  = reg_write_in && hit(reg_addr_in, OFS_PERIOD);
  assign write_control = reg_write_in && hit(reg_addr_in, OFS_CONTROL);
  assign write_enable  = reg_write_in && hit(reg_addr_in, OFS_ENABLE);
  assign write_clear   = reg_write_in && hit(reg_addr_in, OFS_CLEAR);

  // ==========================================================
  // external pin synchroniser and edge detection
  logic pin_sync;
  logic pin_prev;
  logic pin_rise;
  logic pin_fall;

  gtm_sync u_pin_sync
  (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (external_clock_gate_pin_in),
    .sync_out   (pin_sync)
  );

  // previous synchronised pin level
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pin_prev <= 1'b0;
    else
      pin_prev <= pin_sync;
  end

  assign pin_rise = pin_sync && !pin_prev;
  assign pin_fall = !pin_sync && pin_prev;

  // ==========================================================
  // counting mode from the source, sync and gate bits
  typedef enum logic [1:0]
  {
    MODE_TIMER,
    MODE_GATED,
    MODE_SYNC,
    MODE_ASYNC
  } gtm_mode_t;

  gtm_mode_t mode;

  // gate bit only matters with the internal source; the pin clocks otherwise
  always_comb
  begin
    if (!clock_source_select && gate_accumulate_enable)
      mode = MODE_GATED;
    else if (!clock_source_select)
      mode = MODE_TIMER;
    else if (external_sync_select)
      mode = MODE_SYNC;
    else
      mode = MODE_ASYNC;
  end

  // ==========================================================
  // run conditions for idle and sleep
  logic async_mode;
  logic run_ok;

  // async counter: external source with sync bit clear
  assign async_mode = (mode == MODE_ASYNC);

  // idle halts all modes when stop bit set; sleep leaves only async counter
  always_comb
  begin
    run_ok = timer_on_bit;
    if (cpu_idle_in && stop_in_idle_bit)
      run_ok = 1'b0;
    if (cpu_sleep_in && !async_mode)
      run_ok = 1'b0;
  end

  // ==========================================================
  // source selection into prescaler
  logic gated;
  logic src_tick;
  logic pre_tick;

  // gated accumulation relies on internal source chosen by software
  assign gated = (mode == MODE_GATED);

  // one tick source per mode; nothing reaches the prescaler while halted
  // both counter modes use the synchronised pin, as there is one clock
  always_comb
  begin
    src_tick = 1'b0;
    if (run_ok)
    begin
      case (mode)
        MODE_TIMER: src_tick = 1'b1;
        MODE_GATED: src_tick = pin_sync;
        MODE_SYNC:  src_tick = pin_rise;
        MODE_ASYNC: src_tick = pin_rise;
        default:    src_tick = 1'b0;
      endcase
    end
  end

  // prescaler clears on count write or on timer-on falling; while off it
  // simply receives no ticks, so nothing else resets it
  logic prescale_clear;
  assign prescale_clear = write_count ||
                          (write_control && timer_on_bit &&
                           !reg_wdata_in[BIT_TIMER_ON]);

  gtm_prescaler u_prescaler
  (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .clear_in   (prescale_clear),
    .select_in  (prescale_select),
    .tick_in    (src_tick),
    .tick_out   (pre_tick)
  );

  // ==========================================================
  // count step and period match
  logic        match_step;
  logic [15:0] next_count;

  always_comb
  begin
    next_count = count_register;
    match_step = 1'b0;
    if (pre_tick)
    begin
      if (count_register >= period_register)
      begin
        next_count = RST_COUNT;
        match_step = 1'b1;
      end
      else
        next_count = count_register + 16'h0001;
    end
  end

  // count register: software writes win, control writes do not touch it
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      count_register <= RST_COUNT;
    else if (write_count)
      count_register <= reg_wdata_in;
    else
      count_register <= next_count;
  end

  // period register
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      period_register <= RST_PERIOD;
    else if (write_period)
      period_register <= reg_wdata_in;
  end

  // control register, unimplemented bits read zero
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      control_register <= RST_CONTROL;
    else if (write_control)
      control_register <= reg_wdata_in & CONTROL_MASK;
  end

  // ==========================================================
  // interrupt events: match and gate falling edge
  logic [EVT_NUM-1:0] events;
  logic               gate_end;

  assign gate_end = gated && run_ok && pin_fall;
  assign events[EVT_MATCH] = match_step;
  assign events[EVT_GATE]  = gate_end;

  // sticky status per event; a new event wins over a clear
  genvar gi;
  generate
    for (gi = 0; gi < EVT_NUM; gi++)
    begin : g_evt
      always_ff @(posedge clk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
          status[gi] <= 1'b0;
        else if (events[gi])
          status[gi] <= 1'b1;
        else if (write_clear && reg_wdata_in[gi])
          status[gi] <= 1'b0;
      end
    end
  endgenerate

  // interrupt enable register
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      match_interrupt_enable <= '0;
    else if (write_enable)
      match_interrupt_enable <= reg_wdata_in[EVT_NUM-1:0];
  end

  // level interrupt while any enabled flag stands
  assign irq_out = |(status & match_interrupt_enable);

  // ==========================================================
  // read data, one cycle after the read strobe
  // word seen at each offset; clear register and unmapped places read zero
  function automatic logic [15:0] read_word(input logic [3:0] addr);
    case (addr)
      OFS_COUNT:   read_word = count_register;
      OFS_PERIOD:  read_word = period_register;
      OFS_CONTROL: read_word = control_register;
      OFS_STATUS:  read_word = {14'h0000, status};
      OFS_ENABLE:  read_word = {14'h0000, match_interrupt_enable};
      default:     read_word = 16'h0000;
    endcase
  endfunction

  // data stand for one cycle only, then drop back to zero
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      reg_rdata_out <= 16'h0000;
    else if (reg_read_in)
      reg_rdata_out <= read_word(reg_addr_in);
    else
      reg_rdata_out <= 16'h0000;
  end
endmodule

// ===== gtm_timer_assertions.sv
// port checker for the 16-bit timer, bound to its top module
`timescale 1ns/1ps
module gtm_timer_assertions
  import gtm_pkg::*;
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  // register port
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  // power state, pin and interrupt
  input wire logic        cpu_idle_in,
  input wire logic        cpu_sleep_in,
  input wire logic        external_clock_gate_pin_in,
  input wire logic        irq_out
);
  logic [15:0] sh_period, sh_control, sh_count;
  logic [1:0]  sh_enable;
  logic [3:0]  ra_q;
  logic        rd_q, cnt_ok;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // ==========================================================
  // shadows of written registers and of the last read slot
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      sh_period  <= RST_PERIOD;
      sh_control <= RST_CONTROL;
      sh_count   <= RST_COUNT;
      sh_enable  <= 2'h0;
      cnt_ok     <= 1'b1;
      rd_q       <= 1'b0;
      ra_q       <= 4'h0;
    end
    else
    begin
      rd_q <= reg_read_in;
      ra_q <= reg_addr_in;
      if (reg_write_in && reg_addr_in == OFS_PERIOD)
        sh_period <= reg_wdata_in;
      if (reg_write_in && reg_addr_in == OFS_ENABLE)
        sh_enable <= reg_wdata_in[1:0];
      if (reg_write_in && reg_addr_in == OFS_CONTROL)
        sh_control <= reg_wdata_in;
      if (reg_write_in && reg_addr_in == OFS_COUNT)
        sh_count <= reg_wdata_in;
      // count known only if written while stopped and not restarted
      if (reg_write_in && reg_addr_in == OFS_COUNT)
        cnt_ok <= !sh_control[BIT_TIMER_ON];
      else if (reg_write_in && reg_addr_in == OFS_CONTROL && reg_wdata_in[BIT_TIMER_ON])
        cnt_ok <= 1'b0;
    end

  // ==========================================================
  // properties
  property p_rdata_quiet;
    !rd_q |-> reg_rdata_out == 16'h0000;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside slot");
  property p_period_read;
    rd_q && ra_q == OFS_PERIOD |-> reg_rdata_out == sh_period;
  endproperty
  a_period_read: assert property (p_period_read) else $error("period readback wrong");
  property p_control_read;
    rd_q && ra_q == OFS_CONTROL |-> reg_rdata_out == (sh_control & CONTROL_MASK);
  endproperty
  a_control_read: assert property (p_control_read) else $error("control readback wrong");
  property p_status_read;
    rd_q && ra_q == OFS_STATUS |-> reg_rdata_out[15:2] == 14'h0000;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status spare bits set");
  property p_refused_read;
    rd_q && ra_q > OFS_ENABLE |-> reg_rdata_out == 16'h0000;
  endproperty
  a_refused_read: assert property (p_refused_read) else $error("unmapped read not zero");
  property p_count_hold;
    rd_q && ra_q == OFS_COUNT && cnt_ok |-> reg_rdata_out == sh_count;
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("stopped count changed");
  property p_count_step;
    rd_q && ra_q == OFS_COUNT && $past(rd_q) && $past(ra_q) == OFS_COUNT
      && $past(sh_control) == 16'h8000 && !$past(cpu_sleep_in)
      |-> reg_rdata_out == $past(reg_rdata_out) + 16'h0001 || reg_rdata_out == 16'h0000;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");
  property p_irq_status;
    rd_q && ra_q == OFS_STATUS |-> $past(irq_out) == ((reg_rdata_out[1:0] & sh_enable) != 2'h0);
  endproperty
  a_irq_status: assert property (p_irq_status) else $error("irq disagrees with status");
  property p_irq_off;
    reg_write_in && reg_addr_in == OFS_ENABLE && reg_wdata_in[1:0] == 2'h0 |=> !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while all disabled");
endmodule

bind gtm_timer gtm_timer_assertions chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .cpu_idle_in(cpu_idle_in),
  .cpu_sleep_in(cpu_sleep_in), .irq_out(irq_out),
  .external_clock_gate_pin_in(external_clock_gate_pin_in));

// ===== gtm_pin_source.sv
// model of the outside source driving the clock / gate pin
`timescale 1ns/1ps
module gtm_pin_source
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // burst request
  input  wire logic       start_in,
  input  wire logic [7:0] pulses_in,
  input  wire logic [5:0] half_in,
  // pin and status
  output logic            pin_out,
  output logic            busy_out
);
  logic [7:0] left;
  logic [5:0] phase;

  // pulse train, high then low for half_in cycles each; pin rests low
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      left    <= 8'h00;
      phase   <= 6'h00;
      pin_out <= 1'b0;
    end
    else if (start_in && pulses_in != 8'h00)
    begin
      left    <= pulses_in;
      phase   <= half_in;
      pin_out <= 1'b1;
    end
    else if (left != 8'h00)
    begin
      if (phase == 6'h01)
      begin
        phase   <= half_in;
        pin_out <= !pin_out;
        if (pin_out)
          left <= left - 8'h01;
      end
      else
        phase <= phase - 6'h01;
    end

  // busy until the last falling edge
  assign busy_out = left != 8'h00;
endmodule

// ===== tb_general_timer_16bit.sv
// self-checking bench for the 16-bit timer
`timescale 1ns/1ps
module tb_general_timer_16bit;
  import gtm_pkg::*;
  logic        clk_in, reset_n_in, reg_write_in, reg_read_in, irq_out;
  logic        cpu_idle_in, cpu_sleep_in, pin, start, busy, pend;
  logic [3:0]  reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, rnd;
  logic [7:0]  pulses;
  logic [5:0]  half;
  logic [47:0] exp_q[$];
  int          n_mismatch, n_compared, i;

  // ==========================================================
  // design and pin source
  gtm_timer uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .cpu_idle_in(cpu_idle_in), .cpu_sleep_in(cpu_sleep_in),
    .external_clock_gate_pin_in(pin), .irq_out(irq_out));
  gtm_pin_source src (.clk_in(clk_in), .reset_n_in(reset_n_in), .start_in(start),
    .pulses_in(pulses), .half_in(half), .pin_out(pin), .busy_out(busy));

  // clock
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = !clk_in;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // ==========================================================
  // bus cycles; strobes stay up so calls may run back to back
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_write_in <= wr;
    reg_read_in  <= !wr;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, lo, hi);
    exp_q.push_back({m, lo, hi});
    bus(1'b0, a, 16'h0000);
  endtask
  task automatic cyc(input int n);
    @(posedge clk_in);
    reg_write_in <= 1'b0;
    reg_read_in  <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask
  task automatic bad(input logic [15:0] got, lo, hi);
    n_mismatch++;
    $display("BAD t=%0t got=%h want=%h..%h", $time, got, lo, hi);
  endtask
  task automatic chk_irq(input logic want);
    #10;
    n_compared++;
    if (irq_out !== want)
      bad({15'h0000, irq_out}, {15'h0000, want}, {15'h0000, want});
  endtask

  // monitor: the read slot takes the oldest note off the queue
  always @(posedge clk_in)
  begin
    if (pend)
    begin
      logic [47:0] e;
      e = exp_q.pop_front();
      n_compared++;
      if ($isunknown(reg_rdata_out) || (reg_rdata_out & e[47:32]) < e[31:16]
          || (reg_rdata_out & e[47:32]) > e[15:0])
        bad(reg_rdata_out, e[31:16], e[15:0]);
    end
    pend <= reg_read_in;
  end

  // one counting run: clear, start, feed the pin, stop, read count
  task automatic run(input logic [15:0] ctl, input logic [7:0] n, input logic [5:0] h,
                     input int w, input logic idl, slp, input logic [15:0] lo, hi);
    int k;
    cpu_idle_in  <= idl;
    cpu_sleep_in <= slp;
    bus(1'b1, OFS_COUNT, 16'h0000);
    bus(1'b1, OFS_CONTROL, ctl);
    cyc(0);
    start  <= n != 8'h00;
    pulses <= n;
    half   <= h;
    @(posedge clk_in);
    start <= 1'b0;
    @(negedge clk_in);
    for (k = 0; busy && k < 3000; k++)
      @(negedge clk_in);
    if (busy)
      n_mismatch++;
    repeat (w) @(posedge clk_in);
    bus(1'b1, OFS_CONTROL, 16'h0000);
    rd(OFS_COUNT, 16'hffff, lo, hi);
  endtask

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog, well beyond the few thousand cycles of the run
  initial
  begin
    #(100 * 20000);
    n_mismatch++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {reset_n_in, reg_write_in, reg_read_in, cpu_idle_in, cpu_sleep_in, start, pend} = 7'h00;
    reg_addr_in  = 4'h0;
    reg_wdata_in = 16'h0000;
    pulses       = 8'h00;
    half         = 6'h01;
    rnd          = 16'h001e;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    // reset values, unmapped places, read-only status
    bus(1'b1, OFS_STATUS, 16'hffff);
    for (i = 0; i < 16; i++)
      rd(i[3:0], 16'hffff, (i == 1) ? RST_PERIOD : 16'h0000, (i == 1) ? RST_PERIOD : 16'h0000);
    // control writes with random fields leave a stopped count alone
    repeat (4)
    begin
      rnd = lfsr(rnd);
      bus(1'b1, OFS_COUNT, rnd);
      bus(1'b1, OFS_CONTROL, rnd & 16'h7fff);
      rd(OFS_CONTROL, 16'hffff, rnd & 16'h7fff & CONTROL_MASK, rnd & 16'h7fff & CONTROL_MASK);
      rd(OFS_COUNT, 16'hffff, rnd, rnd);
    end
    // free run, back-to-back reads for the step check
    bus(1'b1, OFS_COUNT, 16'h0000);
    bus(1'b1, OFS_CONTROL, 16'h8000);
    cyc(2);
    for (i = 0; i < 3; i++)
      rd(OFS_COUNT, 16'hffff, i[15:0] + 16'h0003, i[15:0] + 16'h0003);
    // period match, sticky flag, mask and clear
    bus(1'b1, OFS_ENABLE, 16'h0003);
    bus(1'b1, OFS_PERIOD, 16'h0005);
    bus(1'b1, OFS_COUNT, 16'h0000);
    cyc(20);
    chk_irq(1'b1);
    rd(OFS_STATUS, 16'h0001, 16'h0001, 16'h0001);
    bus(1'b1, OFS_ENABLE, 16'h0000);
    cyc(1);
    chk_irq(1'b0);
    bus(1'b1, OFS_ENABLE, 16'h0001);
    bus(1'b1, OFS_CONTROL, 16'h0000);
    bus(1'b1, OFS_CLEAR, 16'h0003);
    rd(OFS_STATUS, 16'h0003, 16'h0000, 16'h0000);
    cyc(1);
    chk_irq(1'b0);
    bus(1'b1, OFS_PERIOD, 16'hffff);
    bus(1'b1, OFS_ENABLE, 16'h0003);
    // a count write restarts the prescaler
    bus(1'b1, OFS_COUNT, 16'h0000);
    bus(1'b1, OFS_CONTROL, 16'h8010);
    cyc(4);
    bus(1'b1, OFS_COUNT, 16'h0000);
    cyc(4);
    bus(1'b1, OFS_CONTROL, 16'h0000);
    rd(OFS_COUNT, 16'hffff, 16'h0000, 16'h0000);
    // modes, prescale codes, idle and sleep
    run(16'h8000, 8'h00, 6'h01, 20, 1'b0, 1'b0, 16'd20, 16'd28);
    run(16'h8010, 8'h00, 6'h01, 32, 1'b0, 1'b0, 16'd3, 16'd5);
    run(16'h8020, 8'h00, 6'h01, 256, 1'b0, 1'b0, 16'd3, 16'd5);
    run(16'h8030, 8'h00, 6'h01, 1024, 1'b0, 1'b0, 16'd3, 16'd5);
    run(16'h8040, 8'h01, 6'd20, 6, 1'b0, 1'b0, 16'd18, 16'd22);
    rd(OFS_STATUS, 16'h0002, 16'h0002, 16'h0002);
    run(16'h8006, 8'd10, 6'h02, 6, 1'b0, 1'b0, 16'd10, 16'd10);
    run(16'h8002, 8'd5, 6'h02, 6, 1'b0, 1'b1, 16'd5, 16'd5);
    run(16'h8006, 8'd5, 6'h02, 6, 1'b0, 1'b1, 16'd0, 16'd0);
    run(16'h8000, 8'h00, 6'h01, 20, 1'b0, 1'b1, 16'd0, 16'd0);
    run(16'ha000, 8'h00, 6'h01, 20, 1'b1, 1'b0, 16'd0, 16'd0);
    run(16'h8000, 8'h00, 6'h01, 20, 1'b1, 1'b0, 16'd20, 16'd28);
    run(16'ha002, 8'd5, 6'h02, 6, 1'b1, 1'b0, 16'd0, 16'd0);
    run(16'ha040, 8'h01, 6'd20, 6, 1'b1, 1'b0, 16'd0, 16'd0);
    cyc(4);
    wrap_up();
  end
endmodule
